// file: design/trcfg_consts.vh
// constants of the repeater configuration bank: byte offsets, field
// positions, reset values and startup timing; definitions only
`ifndef TRCFG_CONSTS_VH
`define TRCFG_CONSTS_VH

// byte offsets inside the seven-byte map
`define TRCFG_OFF_RESERVED_BYTE     3'h0
`define TRCFG_OFF_UNUSED_BYTE       3'h1
`define TRCFG_OFF_CHANNEL_ENABLE    3'h2
`define TRCFG_OFF_BOOST_CH1_CH0     3'h3
`define TRCFG_OFF_BOOST_CH3_CH2     3'h4
`define TRCFG_OFF_SWING_ALL         3'h5
`define TRCFG_OFF_EMPHASIS_ALL      3'h6
`define TRCFG_OFF_PAST_END          3'h7

// target address: two fixed ones, strap, two fixed zeros, two straps
`define TRCFG_ADDR_TOP_BITS         2'h3
`define TRCFG_ADDR_MID_BITS         2'h0

// field positions
`define TRCFG_CHEN_LSB              4
`define TRCFG_CHEN_MSB              7

// reset values
`define TRCFG_BYTE_ZERO_RST         8'h00
`define TRCFG_CHEN_UNUSED_RST       4'h0
`define TRCFG_SWING_LOWER_RST       1'b1
// pin synchroniser: scl and sda start at the idle bus level
`define TRCFG_PIN_SYNC_RST          14'h3000

// cycles after reset release before straps are latched
`define TRCFG_STRAP_SETTLE          2'h3

`endif

// file: design/trcfg_top.v
// i2c target and seven-byte configuration bank of a four-channel repeater
// assumes i_clk far faster than the i2c clock; pins arrive asynchronously;
// i_reset acts as the power-up latch strobe for the boost, swing, emphasis and power-enable pins; address straps stay live
`timescale 1ns/1ps
`include "trcfg_consts.vh"

// Summary of operation
// RULE_01: answer address 11,strap,00,strap,strap plus R/W
// RULE_02: byte 2 high nibble enables channels 3..0
// RULE_03: bytes 3,4 hold boost nibbles, strap initialized
// RULE_04: byte 5 swing pairs, upper strap, lower one
// RULE_05: byte 6 emphasis pairs from emphasis straps
// RULE_06: only sequential block access from byte zero
// RULE_07: first written data byte discarded as dummy
// RULE_08: bytes 0,1 read zero, ignore writes
// RULE_09: strap select chooses pins or registers
// RULE_10: boost code sixteen levels, 0000 lowest
// RULE_11: swing code four levels, 00 smallest
module trcfg_top (
	input  wire        i_clk,
	input  wire        i_reset,
	input  wire        i_scl,
	input  wire        i_sda_in,
	input  wire [2:0]  i_addr_strap,
	input  wire        i_power_enable_pin,
	input  wire        i_strap_select,
	input  wire [3:0]  i_boost_code,
	input  wire        i_swing_upper_bit,
	input  wire [1:0]  i_emphasis_level,
	output reg         o_sda_out,
	output reg         o_sda_oe,
	output reg  [3:0]  o_channel_enable,
	output reg         o_power_down,
	output reg  [15:0] o_boost_code,
	output reg  [7:0]  o_swing_code,
	output reg  [7:0]  o_emphasis_level
);

	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_AACK = 7'h04;
	localparam [6:0] ST_WR   = 7'h08;
	localparam [6:0] ST_WACK = 7'h10;
	localparam [6:0] ST_RD   = 7'h20;
	localparam [6:0] ST_RACK = 7'h40;

	// two-stage synchroniser for every pin
	wire [13:0] pin_sync;
	reg         scl_prev;
	reg         sda_prev;
	wire        scl;
	wire        sda;
	wire [2:0]  addr_strap;
	wire        power_enable_pin;
	wire        strap_sel;
	wire [3:0]  boost_pin;
	wire        swing_pin;
	wire [1:0]  emph_pin;

	trcfg_sync2 #(
		.WIDTH (14),
		.RST   (`TRCFG_PIN_SYNC_RST)
	) u_pin_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_scl, i_sda_in, i_addr_strap, i_power_enable_pin, i_strap_select,
			i_boost_code, i_swing_upper_bit, i_emphasis_level}),
		.o_sync  (pin_sync)
	);

	always @(posedge i_clk) begin
		if (i_reset) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	assign scl        = pin_sync[13];
	assign sda        = pin_sync[12];
	assign addr_strap = pin_sync[11:9];
	assign power_enable_pin        = pin_sync[8];
	assign strap_sel  = pin_sync[7];
	assign boost_pin  = pin_sync[6:3];
	assign swing_pin  = pin_sync[2];
	assign emph_pin   = pin_sync[1:0];

	wire scl_rise   = scl & ~scl_prev;
	wire scl_fall   = ~scl & scl_prev;
	wire start_cond = scl & scl_prev & sda_prev & ~sda;
	wire stop_cond  = scl & scl_prev & ~sda_prev & sda;
	wire [6:0] own_addr = {`TRCFG_ADDR_TOP_BITS, addr_strap[2], `TRCFG_ADDR_MID_BITS,
		addr_strap[1:0]};

	// configuration bytes
	reg  [7:0] chen_byte;
	reg  [7:0] boost_lo_byte;
	reg  [7:0] boost_hi_byte;
	reg  [7:0] swing_byte;
	reg  [7:0] emph_byte;
	reg  [1:0] settle_cnt;
	reg        loaded;

	// transfer engine
	reg  [6:0] state;
	reg  [7:0] shreg;
	reg  [3:0] bit_cnt;
	reg  [2:0] ptr;
	reg        is_read;
	reg        dummy_pending;
	reg        wr_stb;
	reg  [2:0] wr_ptr;
	reg  [7:0] wr_data;
	reg  [7:0] rd_cur;

	wire [2:0] ptr_inc = (ptr == `TRCFG_OFF_PAST_END) ? ptr : ptr + 3'h1;

	always @* begin
		case (ptr)
			`TRCFG_OFF_CHANNEL_ENABLE: rd_cur = chen_byte;
			`TRCFG_OFF_BOOST_CH1_CH0:  rd_cur = boost_lo_byte;
			`TRCFG_OFF_BOOST_CH3_CH2:  rd_cur = boost_hi_byte;
			`TRCFG_OFF_SWING_ALL:      rd_cur = swing_byte;
			`TRCFG_OFF_EMPHASIS_ALL:   rd_cur = emph_byte;
			default:                   rd_cur = `TRCFG_BYTE_ZERO_RST; // see RULE_08
		endcase
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			chen_byte     <= `TRCFG_BYTE_ZERO_RST;
			boost_lo_byte <= `TRCFG_BYTE_ZERO_RST;
			boost_hi_byte <= `TRCFG_BYTE_ZERO_RST;
			swing_byte    <= `TRCFG_BYTE_ZERO_RST;
			emph_byte     <= `TRCFG_BYTE_ZERO_RST;
			settle_cnt    <= 2'h0;
			loaded        <= 1'b0;
		end else if (!loaded) begin
			settle_cnt <= settle_cnt + 2'h1;
			if (settle_cnt == `TRCFG_STRAP_SETTLE) begin
				loaded        <= 1'b1;
				chen_byte     <= {{4{power_enable_pin}}, `TRCFG_CHEN_UNUSED_RST}; // see RULE_02
				boost_lo_byte <= {boost_pin, boost_pin}; // see RULE_03
				boost_hi_byte <= {boost_pin, boost_pin}; // see RULE_03
				swing_byte    <= {4{swing_pin, `TRCFG_SWING_LOWER_RST}}; // see RULE_04
				emph_byte     <= {4{emph_pin}}; // see RULE_05
			end
		end else if (wr_stb) begin
			case (wr_ptr)
				`TRCFG_OFF_CHANNEL_ENABLE: chen_byte     <= wr_data; // see RULE_02
				`TRCFG_OFF_BOOST_CH1_CH0:  boost_lo_byte <= wr_data; // see RULE_03
				`TRCFG_OFF_BOOST_CH3_CH2:  boost_hi_byte <= wr_data; // see RULE_03
				`TRCFG_OFF_SWING_ALL:      swing_byte    <= wr_data; // see RULE_04
				`TRCFG_OFF_EMPHASIS_ALL:   emph_byte     <= wr_data; // see RULE_05
				default: ; // see RULE_08
			endcase
		end
	end

	always @(posedge i_clk) begin
		if (i_reset) begin
			state         <= ST_IDLE;
			shreg         <= 8'h00;
			bit_cnt       <= 4'h0;
			ptr           <= 3'h0;
			is_read       <= 1'b0;
			dummy_pending <= 1'b0;
			wr_stb        <= 1'b0;
			wr_ptr        <= 3'h0;
			wr_data       <= 8'h00;
			o_sda_oe      <= 1'b0;
			o_sda_out     <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			if (start_cond && loaded) begin
				state    <= ST_ADDR;
				bit_cnt  <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (stop_cond) begin
				state    <= ST_IDLE;
				o_sda_oe <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: ;
					ST_ADDR, ST_WR: begin
						if (scl_rise) begin
							shreg   <= {shreg[6:0], sda};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							if (state == ST_ADDR) begin
								if (shreg[7:1] == own_addr) begin // see RULE_01
									o_sda_oe      <= 1'b1;
									state         <= ST_AACK;
									is_read       <= shreg[0];
									ptr           <= `TRCFG_OFF_RESERVED_BYTE; // see RULE_06
									dummy_pending <= 1'b1;
								end else begin
									state <= ST_IDLE;
								end
							end else begin
								o_sda_oe <= 1'b1;
								state    <= ST_WACK;
								if (dummy_pending) begin
									dummy_pending <= 1'b0; // see RULE_07
								end else begin
									wr_stb  <= 1'b1;
									wr_ptr  <= ptr;
									wr_data <= shreg;
									ptr     <= ptr_inc; // see RULE_06
								end
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							if (is_read) begin
								shreg    <= {rd_cur[6:0], 1'b0};
								o_sda_oe <= ~rd_cur[7];
								bit_cnt  <= 4'h1;
								ptr      <= ptr_inc; // see RULE_06
								state    <= ST_RD;
							end else begin
								o_sda_oe <= 1'b0;
								state    <= ST_WR;
							end
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							o_sda_oe <= 1'b0;
							state    <= ST_WR;
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							if (bit_cnt == 4'h8) begin
								o_sda_oe <= 1'b0;
								state    <= ST_RACK;
							end else begin
								o_sda_oe <= ~shreg[7];
								shreg    <= {shreg[6:0], 1'b0};
								bit_cnt  <= bit_cnt + 4'h1;
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							state <= sda ? ST_IDLE : ST_AACK;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// drive the analogue settings from registers or straps
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_channel_enable <= 4'h0;
			o_power_down     <= 1'b1;
			o_boost_code     <= 16'h0000;
			o_swing_code     <= 8'h00;
			o_emphasis_level <= 8'h00;
		end else begin
			o_channel_enable <= chen_byte[`TRCFG_CHEN_MSB:`TRCFG_CHEN_LSB]; // see RULE_02
			o_power_down     <= ~power_enable_pin;
			if (strap_sel) begin // see RULE_09
				o_boost_code     <= {4{boost_pin}}; // see RULE_10
				o_swing_code     <= {4{swing_pin, `TRCFG_SWING_LOWER_RST}}; // see RULE_11
				o_emphasis_level <= {4{emph_pin}};
			end else begin
				o_boost_code     <= {boost_hi_byte, boost_lo_byte}; // see RULE_10
				o_swing_code     <= swing_byte; // see RULE_11
				o_emphasis_level <= emph_byte;
			end
		end
	end

endmodule // trcfg_top

// two flip-flops per bit; only the second stage is read outside
module trcfg_sync2 #(
	parameter             WIDTH = 14,
	parameter [WIDTH-1:0] RST   = {WIDTH{1'b0}}
) (
	input  wire             i_clk,
	input  wire             i_reset,
	input  wire [WIDTH-1:0] i_async,
	output reg  [WIDTH-1:0] o_sync
);

	reg [WIDTH-1:0] meta;

	always @(posedge i_clk) begin
		if (i_reset) begin
			meta   <= RST;
			o_sync <= RST;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule // trcfg_sync2

// file: sim/trcfg_asserts.sv
// checker on the ports of trcfg_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module trcfg_asserts (
	input wire        i_clk,
	input wire        i_reset,
	input wire        i_scl,
	input wire        i_strap_select,
	input wire [3:0]  i_boost_code,
	input wire        i_swing_upper_bit,
	input wire [1:0]  i_emphasis_level,
	input wire        o_sda_out,
	input wire        o_sda_oe,
	input wire [3:0]  o_channel_enable,
	input wire [15:0] o_boost_code,
	input wire [7:0]  o_swing_code,
	input wire [7:0]  o_emphasis_level
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	a_sda_open_drain: assert property (!o_sda_out) else $error("sda out high");
	a_oe_scl_low: assert property (
		$changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2)) else $error("sda moved, scl high");
	a_ack_hold: assert property (
		$rose(o_sda_oe) |-> o_sda_oe[*8]) else $error("sda drive too short");
	a_pin_boost: assert property (
		(i_strap_select && $stable(i_boost_code))[*6] |-> o_boost_code == {4{i_boost_code}})
		else $error("boost pins");
	a_pin_swing: assert property (
		(i_strap_select && $stable(i_swing_upper_bit))[*6]
		|-> o_swing_code == {4{i_swing_upper_bit, 1'b1}}) else $error("swing pins");
	a_pin_emph: assert property (
		(i_strap_select && $stable(i_emphasis_level))[*6]
		|-> o_emphasis_level == {4{i_emphasis_level}}) else $error("emph pins");
	a_regs_hold: assert property (
		(i_scl && !i_strap_select)[*8] |-> $stable(o_boost_code) && $stable(o_channel_enable))
		else $error("boost or enable moved");
	a_codes_hold: assert property (
		(i_scl && !i_strap_select)[*8] |-> $stable(o_swing_code) && $stable(o_emphasis_level))
		else $error("swing or emph moved");
endmodule // trcfg_asserts
bind trcfg_top trcfg_asserts u_chk (.i_clk, .i_reset, .i_scl, .i_strap_select, .i_boost_code,
	.i_swing_upper_bit, .i_emphasis_level, .o_sda_out, .o_sda_oe, .o_channel_enable,
	.o_boost_code, .o_swing_code, .o_emphasis_level);

// file: sim/trcfg_host_model.sv
// i2c host model, block access from byte zero only
// assumes sda pulled up at the bench; a released bit is driven 1
`timescale 1ns/1ps
module trcfg_host_model (
	input  wire i_clk,
	input  wire i_sda,
	output reg  o_scl,
	output reg  o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// ten clocks a phase; sda moves only well after scl falls
	task tick;
	begin
		repeat (10) @(posedge i_clk);
		#1;
	end
	endtask
	task start;
	begin
		o_sda = 1'b1;
		tick;
		o_scl = 1'b1;
		tick;
		o_sda = 1'b0;
		tick;
		o_scl = 1'b0;
		tick;
	end
	endtask
	task stop;
	begin
		o_sda = 1'b0;
		tick;
		o_scl = 1'b1;
		tick;
		o_sda = 1'b1;
		tick;
	end
	endtask
	task xfer(input [8:0] d, output [8:0] q);
		integer i;
	begin
		for (i = 8; i >= 0; i = i - 1) begin
			o_sda = d[i];
			tick;
			o_scl = 1'b1;
			tick;
			q[i] = i_sda;
			o_scl = 1'b0;
			tick;
		end
	end
	endtask
endmodule // trcfg_host_model

// file: sim/tmds_repeater_i2c_config_bench.sv
// self-checking bench for trcfg_top
// host model drives scl and sda; sda wired-and here
`timescale 1ns/1ps
module tmds_repeater_i2c_config_bench;
	reg         i_clk;
	reg         i_reset;
	reg  [2:0]  i_addr_strap;
	reg         i_power_enable_pin;
	reg         i_strap_select;
	reg  [3:0]  i_boost_code;
	reg         i_swing_upper_bit;
	reg  [1:0]  i_emphasis_level;
	wire        h_scl;
	wire        h_sda;
	wire        sda;
	wire        o_sda_out;
	wire        o_sda_oe;
	wire [3:0]  o_channel_enable;
	wire        o_power_down;
	wire [15:0] o_boost_code;
	wire [7:0]  o_swing_code;
	wire [7:0]  o_emphasis_level;
	integer     error_cnt;
	integer     n_compared;
	integer     r;
	integer     k;
	reg  [8:0]  q;
	reg  [39:0] rows [0:1];
	reg  [7:0]  m [0:7];
	assign sda = h_sda & ~(o_sda_oe & ~o_sda_out);
	trcfg_top dut (.i_clk, .i_reset, .i_scl(h_scl), .i_sda_in(sda), .i_addr_strap,
		.i_power_enable_pin, .i_strap_select, .i_boost_code, .i_swing_upper_bit,
		.i_emphasis_level, .o_sda_out, .o_sda_oe, .o_channel_enable, .o_power_down,
		.o_boost_code, .o_swing_code, .o_emphasis_level);
	trcfg_host_model host (.i_clk(i_clk), .i_sda(sda), .o_scl(h_scl), .o_sda(h_sda));
	task chk(input [63:0] seen, input [63:0] exp, input string nm);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("unexpected %0s: expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task tally_and_finish;
	begin
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	end
	endtask
	task go(input [2:0] s, input rw, input nak);
	begin
		host.start;
		host.xfer({2'h3, s[2], 2'h0, s[1:0], rw, 1'b1}, q);
		chk(q[0], nak, "addr ack");
	end
	endtask
	task wb(input [7:0] d);
	begin
		host.xfer({d, 1'b1}, q);
		chk(q[0], 1'b0, "data ack");
	end
	endtask
	task rd_all;
	begin
		go(i_addr_strap, 1'b1, 1'b0);
		for (k = 0; k < 8; k = k + 1) begin
			host.xfer({8'hff, k == 7}, q);
			chk(q[8:1], m[k], "read byte");
		end
		host.stop;
	end
	endtask
	task out_chk;
	begin
		chk(o_channel_enable, m[2][7:4], "chen");
		chk(o_boost_code, {m[4], m[3]}, "boost");
		chk(o_swing_code, m[5], "swing");
		chk(o_emphasis_level, m[6], "emph");
		chk(o_sda_out, 1'b0, "sda out");
	end
	endtask
	task pins_to_m;
	begin
		m[3] = {2{i_boost_code}};
		m[4] = m[3];
		m[5] = {4{i_swing_upper_bit, 1'b1}};
		m[6] = {4{i_emphasis_level}};
	end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		repeat (100000) @(posedge i_clk);
		error_cnt = error_cnt + 1;
		tally_and_finish;
	end
	initial begin
		error_cnt = 0;
		n_compared = 0;
		i_reset = 1'b1;
		i_addr_strap = 3'h5;
		i_power_enable_pin = 1'b1;
		i_strap_select = 1'b0;
		i_boost_code = 4'ha;
		i_swing_upper_bit = 1'b0;
		i_emphasis_level = 2'h2;
		rows[0] = {8'ha3, 8'h0f, 8'h5c, 8'h1b, 8'he4};
		rows[1] = {8'h0c, 8'hf0, 8'h3a, 8'he4, 8'h1b};
		for (k = 0; k < 8; k = k + 1) begin
			m[k] = 8'h00;
		end
		m[2] = {{4{i_power_enable_pin}}, 4'h0};
		pins_to_m;
		repeat (12) @(posedge i_clk);
		#1;
		chk(o_channel_enable, 4'h0, "reset chen");
		i_reset = 1'b0;
		repeat (10) @(posedge i_clk);
		#1;
		chk(o_power_down, 1'b0, "power down");
		out_chk;
		rd_all;
		for (r = 0; r < 2; r = r + 1) begin
			go(i_addr_strap, 1'b0, 1'b0);
			wb(8'h5a);
			wb(8'hff);
			wb(8'hff);
			for (k = 2; k < 7; k = k + 1) begin
				m[k] = rows[r][8 * (6 - k) + 7 -: 8];
				wb(m[k]);
			end
			host.stop;
			rd_all;
			out_chk;
		end
		for (k = 0; k < 3; k = k + 1) begin
			go(i_addr_strap ^ (3'h1 << k), 1'b0, 1'b1);
			host.stop;
		end
		for (k = 0; k < 4; k = k + 1) begin
			q[8:2] = {2'h3, i_addr_strap[2], 2'h0, i_addr_strap[1:0]};
			host.start;
			host.xfer({q[8:2] ^ (7'h01 << (k < 2 ? 6 - k : 5 - k)), 2'h1}, q);
			chk(q[0], 1'b1, "fixed addr bit");
			host.stop;
		end
		i_addr_strap = 3'h2;
		rd_all;
		i_strap_select = 1'b1;
		i_boost_code = 4'h3;
		i_swing_upper_bit = 1'b1;
		i_emphasis_level = 2'h1;
		i_power_enable_pin = 1'b0;
		pins_to_m;
		repeat (10) @(posedge i_clk);
		#1;
		out_chk;
		chk(o_power_down, 1'b1, "power down");
		i_reset = 1'b1;
		i_strap_select = 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
		chk(o_channel_enable, 4'h0, "reset chen");
		i_reset = 1'b0;
		repeat (10) @(posedge i_clk);
		#1;
		m[2] = {{4{i_power_enable_pin}}, 4'h0};
		out_chk;
		chk(o_power_down, 1'b1, "power down");
		rd_all;
		tally_and_finish;
	end
endmodule // tmds_repeater_i2c_config_bench
